// file: design/csd_bank_pkg.sv
// Constants, types and fixed contents of the card-specific data bank.
// Assumes a 32-bit APB host port and a 512-byte extended data space.
package card_data_pkg;

  // APB map: extended byte N sits at byte address 4*N
  typedef logic [11:0] apb_addr_t;
  localparam int unsigned EXT_BYTES  = 512;
  localparam apb_addr_t   EXT_LAST   = 12'h7FC;
  localparam apb_addr_t   DATA_WORD0 = 12'h800;
  localparam apb_addr_t   DATA_WORD1 = 12'h804;
  localparam apb_addr_t   DATA_WORD2 = 12'h808;
  localparam apb_addr_t   DATA_WORD3 = 12'h80C;
  localparam apb_addr_t   CTRL_ADDR  = 12'h810;
  localparam apb_addr_t   STAT_ADDR  = 12'h814;

  // Control register fields and reset
  localparam int unsigned CTRL_LINK_EN_BIT   = 0;
  localparam int unsigned CTRL_CNT_CLEAR_BIT = 1;
  localparam logic [1:0]  CTRL_RESET         = 2'h1;

  // Status register field positions
  localparam int unsigned STAT_ACTIVE_BIT = 0;
  localparam int unsigned STAT_DONE_BIT   = 1;
  localparam int unsigned STAT_PTR_LSB    = 8;
  localparam int unsigned STAT_FRAMES_LSB = 16;

  // Writable byte of the data word: bits 15:8
  localparam logic [7:0]  USER_BITS_RESET = 8'h00;
  localparam logic [7:0]  USER_OTP_MASK   = 8'h60;
  localparam int unsigned USER_BITS_LSB   = 8;
  localparam int unsigned USER_STRB_LANE  = 1;

  // Link frame
  localparam logic [6:0]  FRAME_TOP_BIT = 7'h7F;
  localparam logic        LINK_IDLE_LVL = 1'b1;
  localparam logic [6:0]  CRC_POLY      = 7'h09;

  // Card-specific data word, MSB first
  typedef struct packed {
    logic [1:0]  structure;
    logic [3:0]  spec_version;
    logic [1:0]  rsvd_a;
    logic [7:0]  read_access_time;
    logic [7:0]  clock_based_access_time;
    logic [7:0]  max_bus_freq;
    logic [11:0] command_classes;
    logic [3:0]  read_block_length_exp;
    logic        partial_read_allowed;
    logic        write_misalign_flag;
    logic        read_misalign_flag;
    logic        driver_stage_present;
    logic [1:0]  rsvd_b;
    logic [11:0] device_size;
    logic [2:0]  read_current_low_supply;
    logic [2:0]  read_current_high_supply;
    logic [2:0]  write_current_low_supply;
    logic [2:0]  write_current_high_supply;
    logic [2:0]  size_multiplier;
    logic [4:0]  erase_group_size;
    logic [4:0]  erase_group_multiplier;
    logic [4:0]  protect_group_size;
    logic        protect_group_enable;
    logic [1:0]  default_ecc;
    logic [2:0]  write_speed_factor;
    logic [3:0]  write_block_length_exp;
    logic        partial_write_allowed;
    logic [3:0]  rsvd_c;
    logic        content_protect_app;
    logic [7:0]  user_bits;
    logic [6:0]  checksum;
    logic        end_bit;
  } card_word_t;

  localparam card_word_t WORD_FIXED = '{
    2'h3, 4'h4, 2'h0, 8'h0E, 8'h00, 8'h32, 12'h0F5, 4'h9,
    1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 12'hFFF,
    3'h7, 3'h7, 3'h7, 3'h7, 3'h7,
    5'h1F, 5'h1F, 5'h0F, 1'b1, 2'h0, 3'h5, 4'h9, 1'b0,
    4'h0, 1'b0, 8'h00, 7'h00, 1'b1};

  // Fixed extended bytes; all others read zero except the four live count bytes
  typedef struct packed {
    logic [8:0] index;
    logic [7:0] value;
  } ext_entry_t;

  localparam int unsigned EXT_TABLE_LEN = 29;
  localparam ext_entry_t EXT_TABLE [EXT_TABLE_LEN] = '{
    '{9'h0D1, 8'h64}, '{9'h0D2, 8'h00}, '{9'h0D4, 8'h00},
    '{9'h0D5, 8'h00}, '{9'h0D6, 8'hDB}, '{9'h0D7, 8'h01},
    '{9'h0D9, 8'h11}, '{9'h0DB, 8'h09}, '{9'h0DC, 8'h07},
    '{9'h0DD, 8'h01}, '{9'h0DE, 8'h10}, '{9'h0DF, 8'h02},
    '{9'h0E0, 8'h10}, '{9'h0E1, 8'h07}, '{9'h0E2, 8'h10},
    '{9'h0E4, 8'h07}, '{9'h0E5, 8'h42}, '{9'h0E6, 8'h10},
    '{9'h0E7, 8'h15}, '{9'h0E8, 8'h04}, '{9'h0EA, 8'h50},
    '{9'h0EB, 8'h00}, '{9'h0EE, 8'h66}, '{9'h0EF, 8'h22},
    '{9'h0F1, 8'h1E}, '{9'h0F6, 8'h00}, '{9'h1F6, 8'h01},
    '{9'h1F7, 8'h01}, '{9'h1F8, 8'h00}};

  // Live sector count occupies four bytes from here, low byte first
  localparam logic [8:0]  PROG_COUNT_IDX = 9'h0F2;
  localparam logic [31:0] PROG_COUNT_RESET = 32'h0000_0000;

  // Link shift-out states
  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b00,
    LINK_SHIFT = 2'b01,
    LINK_DONE  = 2'b10
  } link_state_t;

endpackage

// file: design/pin_sync3.sv
// Three-stage synchroniser for one pin, with edge pulses.
// Assumes the pin is slow against clk; a level counts once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin and result
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1;
  logic s2;
  logic s3;

  // Stage one feeds only stage two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accepted level and its edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      rise <= (s2 == s3) && s3 && !level;
      fall <= (s2 == s3) && !s3 && level;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// file: design/csd_crc7.sv
// Seven-bit checksum over the upper 120 bits of the data word.
// Purely combinational; the caller registers what it needs.
`timescale 1ns/1ps
`default_nettype none
module card_data_crc7 (
  // Data in, checksum out
  input  wire logic [119:0] data,
  output logic      [6:0]   crc
);
  import card_data_pkg::*;

  // Serial form unrolled, MSB first, polynomial x^7 + x^3 + 1
  always_comb begin
    logic [6:0] c;
    logic       fb;
    c  = 7'h00;
    fb = 1'b0;
    for (int i = 119; i >= 0; i--) begin
      fb = data[i] ^ c[6];
      c  = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    crc = c;
  end
endmodule
`default_nettype wire

// file: design/csd_bank.sv
// Card-specific data bank: 128-bit data word plus extended byte space.
// Assumes an APB master on clk and a host link clock well below clk.
// Function
// - Second read access time field, bits 111:104, reads zero.
// - Maximum bus clock frequency code, bits 103:96, reads 0x32.
// - Read block length exponent, bits 83:80, reads 0x9.
// - Write block length exponent, bits 25:22, reads 0x9.
// - Partial read and both misalignment flags, bits 79:77, read zero.
// - Partial write flag, bit 21, reads zero.
// - All four supply current codes, bits 61:50, read 0x7.
// - Erase group size and multiplier each read 0x1F.
// - Protect group size reads 0x0F; group protection enable bit set.
// - Bit 0 reads one; bits 7:1 carry the checksum.
// - Extended bytes 245:242 count good programmed sectors, from zero.
// - Extended byte 241 reads 0x1E.
// - Extended byte 239 reads 0x22, byte 238 reads 0x66.
// - Extended byte 234 reads 0x50, byte 235 reads zero.
// - Extended byte 209 reads 0x64, byte 210 reads zero.
// - Extended byte 224 reads 0x10.
// - Extended byte 221 reads 0x01.
// - Extended byte 222 reads 0x10.
`timescale 1ns/1ps
`default_nettype none
module card_data_bank (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire card_data_pkg::apb_addr_t paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Host link pins
  input  wire logic                     link_clk,
  input  wire logic                     link_sel,
  output logic                          link_dat,
  // Flash core events
  input  wire logic                     sector_ok
);
  import card_data_pkg::*;

  // Register-bank state
  logic [1:0]  ctrl;
  logic [7:0]  user_bits;
  logic [31:0] prog_count;
  logic [15:0] frames_sent;
  // Data word views
  card_word_t  word_base;
  card_word_t  word_now;
  logic [6:0]  crc_now;
  // Link side
  link_state_t link_state;
  logic [6:0]  bit_ptr;
  logic [127:0] frame_shadow;
  logic        lclk_level;
  logic        lclk_rise;
  logic        lclk_fall;
  logic        lsel_level;
  logic        lsel_rise;
  logic        lsel_fall;
  // Bus strobes
  logic        bus_setup;
  logic        bus_write;
  logic        cnt_clear;
  // Write decode and read views
  logic        ctrl_wr;
  logic        user_wr;
  logic        link_armed;
  logic [7:0]  next_user_bits;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  // Address map check, used by read mux and error flag
  function automatic logic addr_mapped(input apb_addr_t a);
    logic ok;
    ok = 1'b0;
    if (a[1:0] == 2'b00) begin
      ok = (a <= EXT_LAST) || (a == DATA_WORD0) || (a == DATA_WORD1) ||
           (a == DATA_WORD2) || (a == DATA_WORD3) || (a == CTRL_ADDR) ||
           (a == STAT_ADDR);
    end
    return ok;
  endfunction

  // Extended byte lookup: fixed table, then live counter bytes
  function automatic logic [7:0] ext_byte(input logic [8:0] idx,
                                          input logic [31:0] cnt);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < EXT_TABLE_LEN; i++) begin
      if (EXT_TABLE[i].index == idx) begin
        v = EXT_TABLE[i].value;
      end
    end
    if (idx == PROG_COUNT_IDX) begin
      v = cnt[7:0];
    end
    if (idx == 9'(PROG_COUNT_IDX + 9'h001)) begin
      v = cnt[15:8];
    end
    if (idx == 9'(PROG_COUNT_IDX + 9'h002)) begin
      v = cnt[23:16];
    end
    if (idx == 9'(PROG_COUNT_IDX + 9'h003)) begin
      v = cnt[31:24];
    end
    return v;
  endfunction

  // Data word lane for one of its four addresses
  function automatic logic [31:0] word_lane(input card_word_t w, input apb_addr_t a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      DATA_WORD0: v = w[31:0];
      DATA_WORD1: v = w[63:32];
      DATA_WORD2: v = w[95:64];
      DATA_WORD3: v = w[127:96];
      default:    v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Pin synchronisers for the link
  pin_sync3 u_sync_lclk (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (link_clk),
    .level (lclk_level),
    .rise  (lclk_rise),
    .fall  (lclk_fall)
  );

  pin_sync3 u_sync_lsel (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (link_sel),
    .level (lsel_level),
    .rise  (lsel_rise),
    .fall  (lsel_fall)
  );

  // Bus phases; zero wait states, so access always completes
  assign bus_setup = psel && !penable;
  assign bus_write = psel && penable && pwrite;
  assign pready    = psel && penable;
  // Write targets and link qualifier
  assign ctrl_wr    = bus_write && (paddr == CTRL_ADDR);
  assign user_wr    = bus_write && (paddr == DATA_WORD0) && pstrb[USER_STRB_LANE];
  assign cnt_clear  = ctrl_wr && pwdata[CTRL_CNT_CLEAR_BIT];
  assign link_armed = lsel_level && ctrl[CTRL_LINK_EN_BIT] && !lsel_fall;

  // Fixed fields one by one plus host-writable byte; checksum slot left zero
  always_comb begin
    // Header and access timing
    word_base.structure = WORD_FIXED.structure;
    word_base.spec_version = WORD_FIXED.spec_version;
    word_base.rsvd_a = WORD_FIXED.rsvd_a;
    word_base.read_access_time = WORD_FIXED.read_access_time;
    word_base.clock_based_access_time = WORD_FIXED.clock_based_access_time;
    word_base.max_bus_freq = WORD_FIXED.max_bus_freq;
    // Command classes and read block format
    word_base.command_classes = WORD_FIXED.command_classes;
    word_base.read_block_length_exp = WORD_FIXED.read_block_length_exp;
    word_base.partial_read_allowed = WORD_FIXED.partial_read_allowed;
    word_base.write_misalign_flag = WORD_FIXED.write_misalign_flag;
    word_base.read_misalign_flag = WORD_FIXED.read_misalign_flag;
    word_base.driver_stage_present = WORD_FIXED.driver_stage_present;
    word_base.rsvd_b = WORD_FIXED.rsvd_b;
    // Size and supply currents
    word_base.device_size = WORD_FIXED.device_size;
    word_base.read_current_low_supply = WORD_FIXED.read_current_low_supply;
    word_base.read_current_high_supply = WORD_FIXED.read_current_high_supply;
    word_base.write_current_low_supply = WORD_FIXED.write_current_low_supply;
    word_base.write_current_high_supply = WORD_FIXED.write_current_high_supply;
    word_base.size_multiplier = WORD_FIXED.size_multiplier;
    // Erase and protect groups
    word_base.erase_group_size = WORD_FIXED.erase_group_size;
    word_base.erase_group_multiplier = WORD_FIXED.erase_group_multiplier;
    word_base.protect_group_size = WORD_FIXED.protect_group_size;
    word_base.protect_group_enable = WORD_FIXED.protect_group_enable;
    // Write block format
    word_base.default_ecc = WORD_FIXED.default_ecc;
    word_base.write_speed_factor = WORD_FIXED.write_speed_factor;
    word_base.write_block_length_exp = WORD_FIXED.write_block_length_exp;
    word_base.partial_write_allowed = WORD_FIXED.partial_write_allowed;
    // Reserved and content protection
    word_base.rsvd_c = WORD_FIXED.rsvd_c;
    word_base.content_protect_app = WORD_FIXED.content_protect_app;
    // Host-writable byte, checksum slot and end bit
    word_base.user_bits = user_bits;
    word_base.checksum = 7'h00;
    word_base.end_bit = 1'b1;
  end

  // Checksum follows the live contents, never a stale copy
  card_data_crc7 u_crc (
    .data (word_base[127:8]),
    .crc  (crc_now)
  );

  // Word as seen by the host, end bit forced high
  always_comb begin
    word_now          = word_base;
    word_now.checksum = crc_now;
    word_now.end_bit  = 1'b1;
  end

  // Control register; the clear bit is a pulse, not stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (ctrl_wr && pstrb[0]) begin
      ctrl <= {1'b0, pwdata[CTRL_LINK_EN_BIT]};
    end
  end

  // Set-only bits keep their ones, so a stray write can never unprotect
  always_comb begin
    next_user_bits = pwdata[USER_BITS_LSB +: 8] | (user_bits & USER_OTP_MASK);
  end

  // Writable byte of the data word; copy and permanent-protect bits only set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      user_bits <= USER_BITS_RESET;
    end else if (user_wr) begin
      user_bits <= next_user_bits;
    end
  end

  // Good-sector counter; a sector event in the clear cycle is kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_count <= PROG_COUNT_RESET;
    end else if (cnt_clear) begin
      prog_count <= sector_ok ? 32'h0000_0001 : PROG_COUNT_RESET;
    end else if (sector_ok && (prog_count != 32'hFFFF_FFFF)) begin
      prog_count <= prog_count + 32'h0000_0001;
    end
  end

  // Status view of the link
  always_comb begin
    stat_word                        = 32'h0000_0000;
    stat_word[STAT_ACTIVE_BIT]       = (link_state == LINK_SHIFT);
    stat_word[STAT_DONE_BIT]         = (link_state == LINK_DONE);
    stat_word[STAT_PTR_LSB +: 7]     = bit_ptr;
    stat_word[STAT_FRAMES_LSB +: 16] = frames_sent;
  end

  // Read mux; unmapped addresses and writes return zero
  always_comb begin
    rd_word = 32'h0000_0000;
    // Extended bytes first, then the fixed registers
    if (!pwrite && addr_mapped(paddr)) begin
      if (paddr <= EXT_LAST) begin
        rd_word = {24'h000000, ext_byte(paddr[10:2], prog_count)};
      end else if (paddr == CTRL_ADDR) begin
        rd_word = {30'h00000000, ctrl};
      end else if (paddr == STAT_ADDR) begin
        rd_word = stat_word;
      end else begin
        rd_word = word_lane(word_now, paddr);
      end
    end
  end

  // Read data captured in the setup cycle, held through access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (bus_setup) begin
      pslverr <= !addr_mapped(paddr);
      prdata  <= rd_word;
    end
  end

  // Link shift-out: select opens a frame, link clock falls advance it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_state   <= LINK_IDLE;
      bit_ptr      <= FRAME_TOP_BIT;
      frame_shadow <= '0;
      link_dat     <= LINK_IDLE_LVL;
    end else if (!link_armed) begin
      link_state <= LINK_IDLE;
      bit_ptr    <= FRAME_TOP_BIT;
      link_dat   <= LINK_IDLE_LVL;
    end else begin
      case (link_state)
        LINK_IDLE: begin
          if (lsel_rise || lsel_level) begin
            // Snapshot so a bus write cannot tear the frame
            frame_shadow <= word_now;
            link_dat     <= word_now[127];
            bit_ptr      <= FRAME_TOP_BIT;
            link_state   <= LINK_SHIFT;
          end
        end
        LINK_SHIFT: begin
          if (lclk_fall) begin
            if (bit_ptr == 7'h00) begin
              link_dat   <= LINK_IDLE_LVL;
              link_state <= LINK_DONE;
            end else begin
              bit_ptr  <= bit_ptr - 7'h01;
              link_dat <= frame_shadow[bit_ptr - 7'h01];
            end
          end
        end
        LINK_DONE: begin
          link_dat <= LINK_IDLE_LVL;
        end
        default: begin
          link_state <= LINK_IDLE;
        end
      endcase
    end
  end

  // Count of completed frames for software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frames_sent <= 16'h0000;
    end else if ((link_state == LINK_SHIFT) && lclk_fall && (bit_ptr == 7'h00) &&
                 link_armed) begin
      frames_sent <= frames_sent + 16'h0001;
    end
  end

  // Rising link edges are sampled by the host; nothing to do here
  logic unused_rise;
  assign unused_rise = lclk_rise & lclk_level;

endmodule
`default_nettype wire

// file: tb/csd_bank_chk.sv
// Port-level checks of the data bank read-out.
// Sees only the top module ports; bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module card_data_bank_chk
  import card_data_pkg::*;
(
  // Clock and reset
  input wire logic      clk,
  input wire logic      rst_n,
  // APB
  input wire logic      psel,
  input wire logic      penable,
  input wire logic      pwrite,
  input wire apb_addr_t paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic      pready,
  input wire logic      pslverr,
  // Link and core
  input wire logic      link_clk,
  input wire logic      link_sel,
  input wire logic      link_dat,
  input wire logic      sector_ok
);
  // Completed read, the only moment prdata is meaningful
  logic rd;
  assign rd = psel && penable && pready && !pwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_acc2; rd && paddr == DATA_WORD3 |-> prdata[15:8] == 8'h00; endproperty
  a_acc2: assert property (p_acc2) else $error("access time 2 wrong");
  property p_freq; rd && paddr == DATA_WORD3 |-> prdata[7:0] == 8'h32; endproperty
  a_freq: assert property (p_freq) else $error("bus freq code wrong");
  property p_rlen; rd && paddr == DATA_WORD2 |-> prdata[19:16] == 4'h9; endproperty
  a_rlen: assert property (p_rlen) else $error("read length wrong");
  property p_part; rd && paddr == DATA_WORD2 |-> prdata[15:13] == 3'h0; endproperty
  a_part: assert property (p_part) else $error("partial read flags set");
  property p_wlen; rd && paddr == DATA_WORD0 |-> prdata[25:21] == 5'h12; endproperty
  a_wlen: assert property (p_wlen) else $error("write length field wrong");
  property p_curr; rd && paddr == DATA_WORD1 |-> prdata[29:18] == 12'hFFF; endproperty
  a_curr: assert property (p_curr) else $error("current codes wrong");
  property p_ers; rd && paddr == DATA_WORD1 |-> prdata[14:5] == 10'h3FF; endproperty
  a_ers: assert property (p_ers) else $error("erase group wrong");
  property p_wpg; rd && paddr == DATA_WORD1 |-> prdata[4:0] == 5'h0F; endproperty
  a_wpg: assert property (p_wpg) else $error("protect group size wrong");
  property p_wpe; rd && paddr == DATA_WORD0 |-> prdata[31] && prdata[0]; endproperty
  a_wpe: assert property (p_wpe) else $error("enable or end bit clear");
  property p_init; rd && paddr == 12'h3C4 |-> prdata == 32'h0000001E; endproperty
  a_init: assert property (p_init) else $error("init timeout wrong");
endmodule
bind card_data_bank card_data_bank_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .link_sel(link_sel),
  .link_dat(link_dat), .sector_ok(sector_ok));
`default_nettype wire

// file: tb/link_host_model.sv
// Host side of the serial read-out link.
// Clock stands still between frames; it is unrelated to clk.
`timescale 1ns/1ps
`default_nettype none
module link_host_model (
  // Link pins
  output logic      link_clk,
  output logic      link_sel,
  input  wire logic link_dat
);
  initial begin
    link_clk = 1'b0;
    link_sel = 1'b0;
  end
  // One frame of 128 bits, sampled on each rise
  task automatic frame(output logic [127:0] w, output logic tail);
    link_sel = 1'b1;
    #100;
    for (int i = 127; i >= 0; i--) begin
      link_clk = 1'b1;
      w[i] = link_dat;
      #62.5;
      link_clk = 1'b0;
      #62.5;
    end
    #62.5;
    tail = link_dat; // Idle level after the last fall
    link_sel = 1'b0;
    #250;
  endtask
endmodule
`default_nettype wire

// file: tb/card_specific_data_bank_tb.sv
// Self-checking bench for the data bank.
// Drives APB, the core event pin and a host link model.
`timescale 1ns/1ps
`default_nettype none
module card_specific_data_bank_tb;
  import card_data_pkg::*;
  // Stimulus and results
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sector_ok = 1'b0;
  apb_addr_t   paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic [3:0]  pstrb = '0;
  logic        pready, pslverr, link_clk, link_sel, link_dat, rerr;
  int          mismatches = 0;
  int          n_tests = 0;
  // Fixed extended bytes plus two live count bytes, and their values
  localparam logic [8:0] EIDX [16] = '{9'h0D1, 9'h0D2, 9'h0D4, 9'h0D5, 9'h0D6, 9'h0D7, 9'h0DD, 9'h0DE,
    9'h0E0, 9'h0EA, 9'h0EB, 9'h0EE, 9'h0EF, 9'h0F1, 9'h0F2, 9'h0F5};
  localparam logic [7:0] EVAL [16] = '{8'h64, 8'h00, 8'h00, 8'h00, 8'hDB, 8'h01, 8'h01, 8'h10,
    8'h10, 8'h50, 8'h00, 8'h66, 8'h22, 8'h1E, 8'h00, 8'h00};
  always #4 clk = ~clk;
  card_data_bank u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_clk(link_clk), .link_sel(link_sel), .link_dat(link_dat),
    .sector_ok(sector_ok));
  link_host_model u_host (.link_clk(link_clk), .link_sel(link_sel), .link_dat(link_dat));

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_w(input logic [127:0] got, input logic [127:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h", $time, m, got);
    end
  endtask
  // Independent checksum, MSB first, init zero
  function automatic logic [6:0] crc7(input logic [119:0] d);
    logic [6:0] c;
    logic       f;
    c = 7'h00;
    for (int i = 119; i >= 0; i--) begin
      f = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (f ? CRC_POLY : 7'h00);
    end
    return c;
  endfunction
  function automatic logic [127:0] exp_word(input logic [7:0] ub);
    card_word_t c;
    c = WORD_FIXED;
    c.user_bits = ub;
    c.checksum = crc7(c[127:8]);
    return c;
  endfunction
  // One APB transfer; one idle edge after so strobes never toggle twice at once
  task automatic apb(input logic w, input apb_addr_t a, input logic [31:0] d, input logic [3:0] s);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      chk(32'h0, 32'h1, "no pready");
      print_verdict();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_word(input logic [7:0] ub);
    logic [127:0] e;
    e = exp_word(ub);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, DATA_WORD0 + apb_addr_t'(4 * k), '0, 4'h0);
      chk(rdat, e[32*k+:32], "data word");
    end
  endtask
  task automatic t_ext();
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, {1'b0, EIDX[i], 2'b00}, '0, 4'h0);
      chk(rdat, {24'h0, EVAL[i]}, "ext byte");
    end
    apb(1'b1, 12'h3C4, 32'hFFFFFFFF, 4'hF);
    apb(1'b0, 12'h3C4, '0, 4'h0);
    chk(rdat, 32'h0000001E, "ro ext write");
    apb(1'b0, 12'h818, '0, 4'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped err");
    chk(rdat, 32'h0, "unmapped data");
    apb(1'b0, 12'h801, '0, 4'h0);
    chk({31'h0, rerr}, 32'h1, "misaligned err");
  endtask
  task automatic t_user();
    t_word(8'h00);
    apb(1'b1, DATA_WORD3, 32'h0, 4'hF);
    apb(1'b1, DATA_WORD0, 32'hFFFFFFFF, 4'hD);
    t_word(8'h00);
    apb(1'b1, DATA_WORD0, 32'hFFFFFFFF, 4'hF);
    t_word(8'hFF);
    apb(1'b1, DATA_WORD0, 32'h0, 4'hF);
    t_word(8'h60);
  endtask
  task automatic t_count();
    repeat (3) begin
      sector_ok <= 1'b1;
      @(posedge clk);
      sector_ok <= 1'b0;
      @(posedge clk);
    end
    apb(1'b0, 12'h3C8, '0, 4'h0);
    chk(rdat, 32'h3, "sector count");
    apb(1'b1, CTRL_ADDR, 32'h3, 4'hF);
    apb(1'b0, 12'h3C8, '0, 4'h0);
    chk(rdat, 32'h0, "count cleared");
  endtask
  task automatic t_link();
    logic [127:0] w;
    logic         tail;
    u_host.frame(w, tail);
    @(posedge clk);
    chk_w(w, exp_word(8'h60), "link frame");
    chk({31'h0, tail}, 32'h1, "idle after frame");
    apb(1'b0, STAT_ADDR, '0, 4'h0);
    chk({16'h0, rdat[31:16]}, 32'h1, "frames sent");
    apb(1'b1, CTRL_ADDR, 32'h0, 4'hF);
    u_host.frame(w, tail);
    @(posedge clk);
    chk_w(w, '1, "disabled link");
    apb(1'b1, CTRL_ADDR, 32'h1, 4'hF);
  endtask

  // Main sequence; reset held two cycles
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_ext();
    t_user();
    t_count();
    t_link();
    print_verdict();
  end
endmodule
`default_nettype wire
